// ---- design/htc_top.sv ----
`timescale 1ns/1ns

module htc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready_o = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i & in_ready_o & ~flush_i;
  assign pop = out_valid_o & out_ready_i & ~flush_i;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : htc_fifo

module htc_top #(
  parameter int unsigned MATCH_PULSE_CYC = htc_pkg::MATCH_PULSE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // host bus pins
  input wire logic bus_cs_n_i,
  input wire logic bus_rd_n_i,
  input wire logic bus_wr_n_i,
  input wire logic [3:0] bus_addr_i,
  input wire logic [7:0] bus_data_i,
  output logic [7:0] bus_data_o,
  output logic bus_data_oe_o,
  output logic bus_irq_o,
  // time base, byte 0 status and days hundreds down to byte 8 hundreds of ns
  input wire logic [71:0] time_now_i,
  input wire logic ext_event_i,
  input wire logic periodic_i,
  input wire logic pps_i,
  output logic match_pulse_o,
  // internal processor side
  output logic frame_go_o,
  input wire logic frame_accepted_i,
  input wire logic frame_ready_i,
  input wire logic inq_flush_i,
  output logic [7:0] inq_data_o,
  output logic inq_valid_o,
  input wire logic inq_ready_i,
  input wire logic [7:0] outq_data_i,
  input wire logic outq_valid_i,
  output logic outq_ready_o
);
  localparam int unsigned PW = $clog2(MATCH_PULSE_CYC + 1);

  function automatic logic [7:0] time_byte(input logic [71:0] t, input int unsigned idx);
    time_byte = t[8*(htc_pkg::TIME_BYTES-1-idx) +: 8];
  endfunction : time_byte

  // bus pins come from the host clock world
  logic [14:0] bus_sync1_r;
  logic [14:0] bus_sync2_r;
  logic rd_act_prev_r;
  logic wr_act_prev_r;
  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic wr_start;
  logic [3:0] addr;
  logic [7:0] wdata;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_sync1_r <= 15'h7000;
      bus_sync2_r <= 15'h7000;
    end else begin
      bus_sync1_r <= {bus_cs_n_i, bus_rd_n_i, bus_wr_n_i, bus_addr_i, bus_data_i};
      bus_sync2_r <= bus_sync1_r;
    end
  end

  assign rd_act = ~bus_sync2_r[14] & ~bus_sync2_r[13];
  assign wr_act = ~bus_sync2_r[14] & ~bus_sync2_r[12];
  assign addr = bus_sync2_r[11:8];
  assign wdata = bus_sync2_r[7:0];
  // a strobe acts on its leading edge only, so a long cycle pops or clears once
  assign rd_start = rd_act & ~rd_act_prev_r;
  assign wr_start = wr_act & ~wr_act_prev_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_act_prev_r <= 1'b0;
      wr_act_prev_r <= 1'b0;
    end else begin
      rd_act_prev_r <= rd_act;
      wr_act_prev_r <= wr_act;
    end
  end

  logic [7:0] bank_r;
  logic bank1;
  assign bank1 = (bank_r == htc_pkg::BANK_1);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_r <= htc_pkg::RST_BANK;
    end else if (wr_start && addr == htc_pkg::OFF_BANK_SEL) begin
      bank_r <= wdata;
    end
  end

  logic wr_b1;
  logic rd_b1;
  assign wr_b1 = wr_start & bank1;
  assign rd_b1 = rd_start & bank1;

  logic [7:0] ctrl_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= htc_pkg::RST_CTRL;
    end else if (wr_b1 && addr == htc_pkg::OFF_CTRL) begin
      ctrl_r <= wdata;
    end
  end

  logic [7:0] match_r [5];
  always_ff @(posedge sys_clk_i) begin
    if (wr_b1 && addr >= htc_pkg::OFF_MATCH_FIRST && addr <= htc_pkg::OFF_MATCH_LAST) begin
      match_r[3'(addr - htc_pkg::OFF_MATCH_FIRST)] <= wdata;
    end
  end

  // event sources: the pin is synchronised, the others are on-chip
  logic [2:0] ext_sync_r;
  logic periodic_prev_r;
  logic pps_prev_r;
  logic ext_edge;
  logic periodic_rise;
  logic pps_rise;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_sync_r <= 3'h0;
      periodic_prev_r <= 1'b0;
      pps_prev_r <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_event_i};
      periodic_prev_r <= periodic_i;
      pps_prev_r <= pps_i;
    end
  end

  assign ext_edge = ctrl_r[htc_pkg::CTL_EDGE_SEL] ? (ext_sync_r[2] & ~ext_sync_r[1])
                                                   : (~ext_sync_r[2] & ext_sync_r[1]);
  assign periodic_rise = periodic_i & ~periodic_prev_r;
  assign pps_rise = pps_i & ~pps_prev_r;

  // capture registers and hold
  logic [71:0] capture_r;
  logic [63:0] demand_r;
  logic hold_r;
  logic src_capture;
  logic release_wr;
  logic release_rd;

  assign src_capture = ~hold_r & ((ext_edge & ctrl_r[htc_pkg::CTL_EXT_EN])
                     | (periodic_rise & ctrl_r[htc_pkg::CTL_PERIODIC_EN]));
  assign release_wr = wr_b1 & (addr == htc_pkg::OFF_RELEASE);
  assign release_rd = rd_b1 & (addr == htc_pkg::OFF_RELEASE);

  always_ff @(posedge sys_clk_i) begin
    if (release_wr || src_capture) begin
      capture_r <= time_now_i;
    end
    if (rd_start && !bank1 && addr == htc_pkg::OFF_TIME_REQ) begin
      demand_r <= time_now_i[71:8];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_r <= 1'b0;
    end else if (src_capture && ctrl_r[htc_pkg::CTL_HOLD_EN]) begin
      hold_r <= 1'b1;
    end else if (release_rd) begin
      hold_r <= 1'b0;
    end
  end

  // match strobe
  logic match_full;
  logic match_ms;
  logic match_hit;
  logic match_hit_prev_r;
  logic [PW-1:0] pulse_cnt_r;
  logic match_start;

  assign match_ms = time_byte(time_now_i, 5) == match_r[3]
                  && (time_byte(time_now_i, 6) & 8'hF0) == (match_r[4] & 8'hF0); // low nibble is not a strobe digit
  assign match_full = match_ms && time_byte(time_now_i, 2) == match_r[0]
                    && time_byte(time_now_i, 3) == match_r[1] && time_byte(time_now_i, 4) == match_r[2];
  assign match_hit = ctrl_r[htc_pkg::CTL_MATCH_SCOPE] ? match_ms : match_full;
  assign match_start = match_hit & ~match_hit_prev_r & ctrl_r[htc_pkg::CTL_MATCH_EN];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_hit_prev_r <= 1'b0;
      pulse_cnt_r <= '0;
      match_pulse_o <= 1'b0;
    end else begin
      match_hit_prev_r <= match_hit;
      if (!ctrl_r[htc_pkg::CTL_MATCH_EN]) begin
        pulse_cnt_r <= '0;
        match_pulse_o <= 1'b0;
      end else if (match_start) begin
        pulse_cnt_r <= PW'(MATCH_PULSE_CYC - 1);
        match_pulse_o <= 1'b1;
      end else if (pulse_cnt_r != '0) begin
        pulse_cnt_r <= pulse_cnt_r - PW'(1);
      end else begin
        match_pulse_o <= 1'b0;
      end
    end
  end

  // byte queues
  logic outq_valid;
  logic [7:0] outq_byte;
  logic outq_flush;
  logic outq_pop;
  logic inq_push;

  assign outq_flush = wr_b1 && addr == htc_pkg::OFF_HANDSHAKE && wdata[htc_pkg::HS_OUTQ_NONEMPTY];
  assign outq_pop = rd_b1 && addr == htc_pkg::OFF_FRAME_PORT;
  assign inq_push = wr_b1 && addr == htc_pkg::OFF_FRAME_PORT;

  // bytes pass untouched so frame markers reach the processor; a write to a full queue is dropped
  htc_fifo #(.WIDTH(8), .DEPTH(htc_pkg::QUEUE_DEPTH)) u_inq (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(inq_flush_i),
    .in_valid_i(inq_push),
    .in_ready_o(),
    .in_data_i(wdata),
    .out_valid_o(inq_valid_o),
    .out_ready_i(inq_ready_i),
    .out_data_o(inq_data_o)
  );

  htc_fifo #(.WIDTH(8), .DEPTH(htc_pkg::QUEUE_DEPTH)) u_outq (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(outq_flush),
    .in_valid_i(outq_valid_i),
    .in_ready_o(outq_ready_o),
    .in_data_i(outq_data_i),
    .out_valid_o(outq_valid),
    .out_ready_i(outq_pop),
    .out_data_o(outq_byte)
  );

  // handshake bits 0..2, set wins over a same-cycle clear
  logic [2:0] hs_r;
  logic [2:0] hs_set;
  logic [2:0] hs_clr;
  assign hs_set = {frame_ready_i, pps_rise, frame_accepted_i};
  assign hs_clr = (wr_b1 && addr == htc_pkg::OFF_HANDSHAKE) ? (wdata[2:0] & htc_pkg::HS_W1C_MASK) : 3'h0;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_r <= htc_pkg::RST_HS;
    end else begin
      hs_r <= (hs_r & ~hs_clr) | hs_set;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_go_o <= 1'b0;
    end else begin
      frame_go_o <= wr_b1 && addr == htc_pkg::OFF_HANDSHAKE && wdata[htc_pkg::HS_FRAME_GO];
    end
  end

  // interrupt enable and flags
  logic [4:0] irq_en_r;
  logic [4:0] irq_flag_r;
  logic [4:0] irq_pend_r;
  logic [4:0] irq_src;
  logic [4:0] irq_clr;
  logic [4:0] irq_flag_nxt;

  assign irq_src = {frame_ready_i, pps_rise, match_start, periodic_rise, ext_edge};
  assign irq_clr = (wr_b1 && addr == htc_pkg::OFF_IRQ_FLAG) ? wdata[4:0] : 5'h00;
  assign irq_flag_nxt = (irq_flag_r & ~irq_clr) | irq_src;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_en_r <= htc_pkg::RST_IRQ;
    end else if (wr_b1 && addr == htc_pkg::OFF_IRQ_ENABLE) begin
      irq_en_r <= wdata[4:0];
    end
  end

  // pending marks a 0 to 1 flag change seen while enabled; it ends with the flag or the enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_flag_r <= htc_pkg::RST_IRQ;
      irq_pend_r <= htc_pkg::RST_IRQ;
      bus_irq_o <= 1'b0;
    end else begin
      irq_flag_r <= irq_flag_nxt;
      irq_pend_r <= (irq_pend_r | (irq_flag_nxt & ~irq_flag_r & irq_en_r)) & irq_flag_nxt & irq_en_r;
      bus_irq_o <= |irq_pend_r;
    end
  end

  // read data, captured at the leading edge and held for the strobe
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (addr == htc_pkg::OFF_BANK_SEL) begin
      rd_mux = bank_r;
    end else if (!bank1) begin
      if (addr >= htc_pkg::OFF_DEMAND_FIRST && addr <= htc_pkg::OFF_DEMAND_LAST) begin
        rd_mux = time_byte({demand_r, 8'h00}, 32'(addr - htc_pkg::OFF_DEMAND_FIRST));
      end
    end else begin
      case (addr)
        htc_pkg::OFF_CTRL: rd_mux = ctrl_r;
        htc_pkg::OFF_HANDSHAKE: begin
          rd_mux = {3'h0, outq_valid, 1'b0, hs_r};
        end
        htc_pkg::OFF_IRQ_ENABLE: rd_mux = {3'h0, irq_en_r};
        htc_pkg::OFF_IRQ_FLAG: rd_mux = {3'h0, irq_flag_r};
        htc_pkg::OFF_FRAME_PORT: rd_mux = outq_valid ? outq_byte : 8'h00;
        default: begin
          if (addr >= htc_pkg::OFF_CAPTURE_FIRST && addr <= htc_pkg::OFF_CAPTURE_LAST) begin
            rd_mux = time_byte(capture_r, 32'(addr - htc_pkg::OFF_CAPTURE_FIRST));
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_data_o <= 8'h00;
      bus_data_oe_o <= 1'b0;
    end else begin
      if (rd_start) begin
        bus_data_o <= rd_mux;
      end
      bus_data_oe_o <= rd_act;
    end
  end
endmodule : htc_top

// ---- include/htc_pkg.sv ----
package htc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned TIME_BYTES = 9;
  localparam int unsigned QUEUE_DEPTH = 512;
  // shared offsets
  localparam logic [3:0] OFF_BANK_SEL = 4'hF;
  // bank 0
  localparam logic [3:0] OFF_TIME_REQ = 4'h0;
  localparam logic [3:0] OFF_DEMAND_FIRST = 4'h1;
  localparam logic [3:0] OFF_DEMAND_LAST = 4'h8;
  // bank 1
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_CAPTURE_FIRST = 4'h1;
  localparam logic [3:0] OFF_CAPTURE_LAST = 4'h9;
  localparam logic [3:0] OFF_MATCH_FIRST = 4'h3;
  localparam logic [3:0] OFF_MATCH_LAST = 4'h7;
  localparam logic [3:0] OFF_RELEASE = 4'hA;
  localparam logic [3:0] OFF_HANDSHAKE = 4'hB;
  localparam logic [3:0] OFF_IRQ_ENABLE = 4'hC;
  localparam logic [3:0] OFF_IRQ_FLAG = 4'hD;
  localparam logic [3:0] OFF_FRAME_PORT = 4'hE;
  // bank codes
  localparam logic [7:0] BANK_0 = 8'h00;
  localparam logic [7:0] BANK_1 = 8'h01;
  // capture and match control bits
  localparam int unsigned CTL_HOLD_EN = 0;
  localparam int unsigned CTL_PERIODIC_EN = 1;
  localparam int unsigned CTL_EDGE_SEL = 2;
  localparam int unsigned CTL_EXT_EN = 3;
  localparam int unsigned CTL_MATCH_EN = 4;
  localparam int unsigned CTL_MATCH_SCOPE = 5;
  // handshake bits
  localparam int unsigned HS_FRAME_ACCEPTED = 0;
  localparam int unsigned HS_PPS = 1;
  localparam int unsigned HS_FRAME_READY = 2;
  localparam int unsigned HS_OUTQ_NONEMPTY = 4;
  localparam int unsigned HS_FRAME_GO = 7;
  localparam logic [2:0] HS_W1C_MASK = 3'h7;
  // interrupt sources
  localparam int unsigned IRQ_N = 5;
  localparam int unsigned IRQ_EXT = 0;
  localparam int unsigned IRQ_PERIODIC = 1;
  localparam int unsigned IRQ_MATCH = 2;
  localparam int unsigned IRQ_PPS = 3;
  localparam int unsigned IRQ_FRAME = 4;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_BANK = 8'h00;
  localparam logic [4:0] RST_IRQ = 5'h00;
  localparam logic [2:0] RST_HS = 3'h0;
  // timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned MATCH_PULSE_US = 1000;
  localparam int unsigned MATCH_PULSE_CYC = MATCH_PULSE_US * CLK_MHZ;
endpackage : htc_pkg

// ---- bench/htc_chk.sv ----
`timescale 1ns/1ns

module htc_chk #(
  parameter int unsigned MATCH_PULSE_CYC = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic bus_cs_n_i,
  input wire logic bus_rd_n_i,
  input wire logic bus_wr_n_i,
  input wire logic [7:0] bus_data_o,
  input wire logic bus_data_oe_o,
  input wire logic match_pulse_o,
  input wire logic frame_go_o,
  input wire logic inq_flush_i,
  input wire logic [7:0] inq_data_o,
  input wire logic inq_valid_o,
  input wire logic inq_ready_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // counts high cycles of the strobe; the count seen at the falling edge is the full width
  int unsigned hi_cnt_r;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_cnt_r <= 0;
    end else if (match_pulse_o) begin
      hi_cnt_r <= hi_cnt_r + 1;
    end else begin
      hi_cnt_r <= 0;
    end
  end

  a_read_drives_bus: assert property ((!bus_cs_n_i && !bus_rd_n_i) [*4] |-> bus_data_oe_o)
    else $error("read strobe held but data not driven");
  a_oe_has_cause: assert property ($rose(bus_data_oe_o) |-> $past(!bus_rd_n_i, 2) && $past(!bus_cs_n_i, 2))
    else $error("data driven without a read strobe");
  a_oe_released: assert property ($rose(bus_rd_n_i) |-> ##[1:4] !bus_data_oe_o)
    else $error("data still driven after read ended");
  a_data_stands: assert property (bus_data_oe_o && $past(bus_data_oe_o) |-> $stable(bus_data_o))
    else $error("read data changed while driven");
  a_no_oe_write: assert property (!bus_wr_n_i |-> !bus_data_oe_o)
    else $error("data driven during a write");
  a_go_single: assert property (frame_go_o |=> !frame_go_o)
    else $error("frame go longer than one cycle");
  a_go_from_write: assert property (frame_go_o |-> $past(!bus_wr_n_i, 3))
    else $error("frame go without a write");
  a_match_width: assert property ($fell(match_pulse_o) |-> hi_cnt_r == MATCH_PULSE_CYC)
    else $error("match pulse width wrong");
  a_inq_hold: assert property (inq_valid_o && !inq_ready_i && !inq_flush_i |=> inq_valid_o && $stable(inq_data_o))
    else $error("input queue head dropped while stalled");
endmodule : htc_chk

bind htc_top htc_chk #(.MATCH_PULSE_CYC(MATCH_PULSE_CYC)) u_chk (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .bus_cs_n_i(bus_cs_n_i),
  .bus_rd_n_i(bus_rd_n_i),
  .bus_wr_n_i(bus_wr_n_i),
  .bus_data_o(bus_data_o),
  .bus_data_oe_o(bus_data_oe_o),
  .match_pulse_o(match_pulse_o),
  .frame_go_o(frame_go_o),
  .inq_flush_i(inq_flush_i),
  .inq_data_o(inq_data_o),
  .inq_valid_o(inq_valid_o),
  .inq_ready_i(inq_ready_i)
);

// ---- bench/htc_host.sv ----
`timescale 1ns/1ns

module htc_host (
  input wire logic sys_clk_i,
  input wire logic [7:0] rdata_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [3:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 4'h0;
    wdata_o = 8'h00;
  end

  // strobe low four edges covers sync plus register; five high keeps one action per strobe
  task automatic cyc(input logic [3:0] a, input logic [7:0] d, input logic w, output logic [7:0] r);
    @(negedge sys_clk_i);
    addr_o = a;
    wdata_o = d;
    cs_n_o = 1'b0;
    rd_n_o = w;
    wr_n_o = !w;
    repeat (4) @(posedge sys_clk_i);
    r = rdata_i;
    @(negedge sys_clk_i);
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    // released lines show no stale value
    addr_o = ~a;
    wdata_o = ~d;
    repeat (5) @(negedge sys_clk_i);
  endtask : cyc
endmodule : htc_host

// ---- bench/testbench.sv ----
`timescale 1ns/1ns

module testbench;
  localparam int PW = 20;
  logic sys_clk_i, rst_n_i, bus_cs_n_i, bus_rd_n_i, bus_wr_n_i, bus_data_oe_o, bus_irq_o, match_pulse_o;
  logic ext_event_i, periodic_i, pps_i, frame_go_o, frame_accepted_i, frame_ready_i, inq_flush_i;
  logic inq_valid_o, inq_ready_i, outq_valid_i, outq_ready_o, seen;
  logic [3:0] bus_addr_i;
  logic [7:0] bus_data_i, bus_data_o, inq_data_o, outq_data_i, rd_v;
  logic [71:0] time_now_i, t0;
  logic [7:0] q[$];
  int fail_count, cmp_count, cyc, go_seen, n;

  htc_top #(.MATCH_PULSE_CYC(PW)) DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_cs_n_i(bus_cs_n_i),
    .bus_rd_n_i(bus_rd_n_i), .bus_wr_n_i(bus_wr_n_i), .bus_addr_i(bus_addr_i), .bus_data_i(bus_data_i),
    .bus_data_o(bus_data_o), .bus_data_oe_o(bus_data_oe_o), .bus_irq_o(bus_irq_o), .time_now_i(time_now_i),
    .ext_event_i(ext_event_i), .periodic_i(periodic_i), .pps_i(pps_i), .match_pulse_o(match_pulse_o),
    .frame_go_o(frame_go_o), .frame_accepted_i(frame_accepted_i), .frame_ready_i(frame_ready_i),
    .inq_flush_i(inq_flush_i), .inq_data_o(inq_data_o), .inq_valid_o(inq_valid_o), .inq_ready_i(inq_ready_i),
    .outq_data_i(outq_data_i), .outq_valid_i(outq_valid_i), .outq_ready_o(outq_ready_o));

  htc_host u_host (.sys_clk_i(sys_clk_i), .rdata_i(bus_data_o), .cs_n_o(bus_cs_n_i), .rd_n_o(bus_rd_n_i),
    .wr_n_o(bus_wr_n_i), .addr_o(bus_addr_i), .wdata_o(bus_data_i));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_host.cyc(a, d, 1'b1, r);
  endtask : wr

  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] r;
    u_host.cyc(a, 8'h00, 1'b0, r);
    chk(r, e);
  endtask : rc

  task automatic tcmp(input logic [3:0] f, input int cnt, input logic [71:0] t);
    for (int k = 0; k < cnt; k++) begin
      rc(4'(f + k), t[71 - 8 * k -: 8]);
    end
  endtask : tcmp

  task automatic pulse(ref logic s);
    @(negedge sys_clk_i);
    s = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    s = 1'b0;
    repeat (4) @(negedge sys_clk_i);
  endtask : pulse

  function automatic logic [71:0] rt();
    return {8'($urandom), 32'($urandom), 32'($urandom)};
  endfunction : rt

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (frame_go_o === 1'b1) go_seen++;
    if (cyc == 60000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    rst_n_i = 1'b0;
    {ext_event_i, periodic_i, pps_i, frame_accepted_i, frame_ready_i, inq_flush_i, inq_ready_i, outq_valid_i} = '0;
    outq_data_i = 8'h00;
    time_now_i = '0;
    void'($urandom(16509));
    repeat (6) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    rc(htc_pkg::OFF_BANK_SEL, htc_pkg::RST_BANK);
    wr(htc_pkg::OFF_BANK_SEL, htc_pkg::BANK_1);
    rc(htc_pkg::OFF_BANK_SEL, htc_pkg::BANK_1);
    rc(htc_pkg::OFF_CTRL, htc_pkg::RST_CTRL);
    wr(htc_pkg::OFF_IRQ_ENABLE, 8'hE8);
    rc(htc_pkg::OFF_IRQ_ENABLE, 8'h08);
    pulse(pps_i);
    chk(8'(bus_irq_o), 8'h01);
    rc(htc_pkg::OFF_HANDSHAKE, 8'h02);
    wr(htc_pkg::OFF_IRQ_FLAG, 8'hF7);
    rc(htc_pkg::OFF_IRQ_FLAG, 8'h08);
    wr(htc_pkg::OFF_IRQ_FLAG, 8'h08);
    chk(8'(bus_irq_o), 8'h00);
    wr(htc_pkg::OFF_IRQ_ENABLE, 8'h00);
    pulse(periodic_i);
    chk(8'(bus_irq_o), 8'h00);
    wr(htc_pkg::OFF_HANDSHAKE, 8'h02);
    pulse(frame_accepted_i);
    pulse(frame_ready_i);
    rc(htc_pkg::OFF_HANDSHAKE, 8'h05);
    wr(htc_pkg::OFF_HANDSHAKE, 8'h01);
    rc(htc_pkg::OFF_HANDSHAKE, 8'h04);
    wr(htc_pkg::OFF_HANDSHAKE, 8'h04);
    rc(htc_pkg::OFF_HANDSHAKE, 8'h00);
    rc(htc_pkg::OFF_IRQ_FLAG, 8'h12);
    done("irq_handshake");
    // frame format of the host side
    q = {8'h01, 8'(8'h41 + $urandom % 26)};
    repeat (1 + $urandom % 6) q.push_back(8'(8'h30 + $urandom % 10));
    q.push_back(8'h17);
    foreach (q[i]) wr(htc_pkg::OFF_FRAME_PORT, q[i]);
    wr(htc_pkg::OFF_HANDSHAKE, 8'h80);
    chk(8'(go_seen), 8'h01);
    foreach (q[i]) begin
      do begin
        @(negedge sys_clk_i);
        inq_ready_i = 1'($urandom % 2);
      end while (!(inq_ready_i && inq_valid_o === 1'b1));
      chk(inq_data_o, q[i]);
    end
    @(negedge sys_clk_i);
    inq_ready_i = 1'b0;
    chk(8'(inq_valid_o), 8'h00);
    done("input_queue");
    q.delete();
    n = 0;
    while (outq_ready_o === 1'b1 && n < 600) begin
      outq_data_i = 8'($urandom);
      outq_valid_i = 1'b1;
      q.push_back(outq_data_i);
      n++;
      @(negedge sys_clk_i);
    end
    outq_valid_i = 1'b0;
    chk(8'(n == int'(htc_pkg::QUEUE_DEPTH)), 8'h01);
    rc(htc_pkg::OFF_HANDSHAKE, 8'h10);
    repeat (3) begin
      u_host.cyc(htc_pkg::OFF_FRAME_PORT, 8'h00, 1'b0, rd_v);
      chk(rd_v, q.pop_front());
    end
    wr(htc_pkg::OFF_HANDSHAKE, 8'h10);
    rc(htc_pkg::OFF_HANDSHAKE, 8'h00);
    rc(htc_pkg::OFF_FRAME_PORT, 8'h00);
    chk(8'(outq_ready_o), 8'h01);
    done("output_queue");
    t0 = rt();
    time_now_i = t0;
    wr(htc_pkg::OFF_RELEASE, 8'h5A);
    time_now_i = rt();
    tcmp(htc_pkg::OFF_CAPTURE_FIRST, 9, t0);
    wr(htc_pkg::OFF_IRQ_FLAG, 8'h1F);
    wr(htc_pkg::OFF_CTRL, 8'h09);
    t0 = rt();
    time_now_i = t0;
    pulse(ext_event_i);
    time_now_i = rt();
    pulse(ext_event_i);
    tcmp(htc_pkg::OFF_CAPTURE_FIRST, 9, t0);
    rc(htc_pkg::OFF_IRQ_FLAG, 8'h01);
    rc(htc_pkg::OFF_RELEASE, 8'h00);
    wr(htc_pkg::OFF_CTRL, 8'h0E);
    t0 = rt();
    time_now_i = t0;
    pulse(periodic_i);
    time_now_i = rt();
    tcmp(htc_pkg::OFF_CAPTURE_FIRST, 9, t0);
    ext_event_i = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    t0 = rt();
    time_now_i = t0;
    ext_event_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    time_now_i = rt();
    tcmp(htc_pkg::OFF_CAPTURE_FIRST, 9, t0);
    wr(htc_pkg::OFF_BANK_SEL, htc_pkg::BANK_0);
    t0 = rt();
    time_now_i = t0;
    rc(htc_pkg::OFF_TIME_REQ, 8'h00);
    time_now_i = rt();
    tcmp(htc_pkg::OFF_DEMAND_FIRST, 8, t0);
    wr(htc_pkg::OFF_BANK_SEL, htc_pkg::BANK_1);
    done("capture");
    wr(htc_pkg::OFF_CTRL, 8'h00);
    t0 = rt();
    for (int k = 2; k < 7; k++) begin
      wr(4'(1 + k), t0[71 - 8 * k -: 8]);
    end
    wr(htc_pkg::OFF_IRQ_FLAG, 8'h1F);
    // full match, then ms-only with hours off, then disabled
    for (int c = 0; c < 3; c++) begin
      time_now_i = ~t0;
      wr(htc_pkg::OFF_CTRL, c == 0 ? 8'h10 : (c == 1 ? 8'h30 : 8'h00));
      time_now_i = (c == 1) ? (t0 ^ {16'h0, 8'hFF, 48'h0}) : t0;
      seen = 1'b0;
      repeat (6) begin
        @(negedge sys_clk_i);
        seen = seen | match_pulse_o;
      end
      chk(8'(seen), 8'(c < 2));
      repeat (PW) @(negedge sys_clk_i);
    end
    rc(htc_pkg::OFF_IRQ_FLAG, 8'h04);
    done("match");
    complete_run();
  end
endmodule : testbench
